// ### kmp_dev_model.sv
// behavioural serial device on channel one; it only ever pulls lines low
`timescale 1ns/1ps

module kmp_dev_model (
  // resolved lines
  input wire logic clk_line,
  input wire logic dat_line,
  // pull-down drives
  output logic clk_low,
  output logic dat_low
);
  initial begin
    clk_low = 1'b0;
    dat_low = 1'b0;
  end

  task automatic hold_clk(input logic v);
    clk_low = v;
  endtask

  // one 400 ns period; data sampled just before the fall
  task automatic tick(output logic s);
    #190;
    s = dat_line;
    #10;
    clk_low = 1'b1;
    #200;
    clk_low = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    logic s;
    // keep pin changes off the controller's clock edges
    #10;
    f = {~bad_stop, ~^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_low = ~f[i];
      tick(s);
    end
    dat_low = 1'b0;
  endtask

  task automatic recv(output logic [7:0] d, output logic par, output logic stop);
    logic [9:0] f;
    logic s;
    #10;
    // host asks to send by clock high with data low
    for (int i = 0; i < 400 && !(clk_line && !dat_line); i++) #50;
    tick(s);
    for (int i = 0; i < 9; i++) tick(f[i]);
    #190;
    f[9] = dat_line;
    dat_low = 1'b1;
    #10;
    clk_low = 1'b1;
    #200;
    clk_low = 1'b0;
    #200;
    dat_low = 1'b0;
    d = f[7:0];
    par = f[8];
    stop = f[9];
  endtask
endmodule

// ### kmp_pkg.sv
// types shared by the port register block
package kmp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_DONE
  } kmp_state_t;

  // clocks in the upper three bits, data in the lower three
  typedef struct packed {
    logic [2:0] clk;
    logic [2:0] dat;
  } kmp_lines_t;

endpackage

// ### kmp_port_regs.sv
// three-channel serial port controller registers and shift engine
`timescale 1ns/1ps
`include "kmp_port_regs.svh"

module kmp_port_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // open-drain link lines
  input wire kmp_pkg::kmp_lines_t line_in,
  output kmp_pkg::kmp_lines_t line_out,
  output kmp_pkg::kmp_lines_t line_oe,
  output kmp_pkg::kmp_lines_t pullup_on,
  // channel interrupts
  output logic [2:0] channel_irq
);

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  function automatic logic [5:0] dbn_len(input logic [2:0] code);
    if (code > 3'd5) begin
      dbn_len = `KMP_DBN_MAX;
    end else begin
      dbn_len = 6'd1 << code;
    end
  endfunction

  function automatic logic [2:0] lowest(input logic [2:0] v);
    if (v[0]) begin
      lowest = 3'b001;
    end else if (v[1]) begin
      lowest = 3'b010;
    end else if (v[2]) begin
      lowest = 3'b100;
    end else begin
      lowest = 3'b000;
    end
  endfunction

  // -----------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------
  logic [7:0] port_data_byte;
  logic start_flag;
  logic end_flag;
  logic parity_error_flag;
  logic [2:0] active_channel_field;
  logic frame_error_flag;
  logic [7:0] port_control;
  logic [5:0] line_output_control;
  logic [2:0] interrupt_enables;
  kmp_pkg::kmp_lines_t sync1;
  kmp_pkg::kmp_lines_t sync2;
  logic [2:0] deb;
  logic [2:0] deb_prev;
  logic [5:0] dcnt [3];
  kmp_pkg::kmp_state_t state;
  logic [3:0] edges;
  logic [7:0] shreg;
  logic par_bit;
  logic tx_bit;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_pend;
  logic [7:0] rd_addr;
  logic [5:0] prev_low;
  logic [1:0] hcnt [6];

  logic eng_on;
  logic transmit_select;
  logic eng_rst;
  logic [2:0] fall;
  logic [2:0] cand;
  logic [2:0] chan;
  logic cur_dat;
  logic cur_fall;
  logic start_now;
  logic [2:0] clk_low;
  logic [2:0] dat_low;
  logic [5:0] want_low;
  logic [1:0] next_hcnt [6];
  logic [5:0] next_oe;
  logic sw_wr;
  logic [7:0] wdat;
  logic [7:0] rd_val;

  assign eng_on = port_control[`KMP_CTL_EN];
  assign transmit_select = port_control[`KMP_CTL_XMT];
  assign eng_rst = ~eng_on | (line_output_control[5:3] == 3'b000);
  assign sw_wr = wr_pend;
  assign wdat = hwdata[7:0];

  // -----------------------------------------------------------
  // line synchronisers and debounce
  // -----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= line_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deb <= 3'b111;
      deb_prev <= 3'b111;
      for (int i = 0; i < 3; i++) begin
        dcnt[i] <= 6'd0;
      end
    end else begin
      deb_prev <= deb;
      for (int i = 0; i < 3; i++) begin
        if (sync2.clk[i] == deb[i]) begin
          dcnt[i] <= 6'd0;
        end else if (dcnt[i] + 6'd1 >= dbn_len(port_control[6:4])) begin
          deb[i] <= sync2.clk[i];
          dcnt[i] <= 6'd0;
        end else begin
          dcnt[i] <= dcnt[i] + 6'd1;
        end
      end
    end
  end

  assign fall = deb_prev & ~deb;

  // -----------------------------------------------------------
  // start detection and channel select
  // -----------------------------------------------------------
  // falling clock with data low
  assign cand = fall & ~sync2.dat & line_output_control[5:3];
  assign chan = lowest(cand);
  assign start_now = (state == kmp_pkg::ST_IDLE) && (cand != 3'b000);
  assign cur_dat = |(active_channel_field & sync2.dat);
  assign cur_fall = |(active_channel_field & fall);

  // -----------------------------------------------------------
  // shift engine
  // -----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= kmp_pkg::ST_IDLE;
      edges <= 4'd0;
      shreg <= 8'h00;
      par_bit <= 1'b0;
      tx_bit <= 1'b1;
    end else if (eng_rst) begin
      state <= kmp_pkg::ST_IDLE;
      edges <= 4'd0;
      tx_bit <= 1'b1;
    end else begin
      unique case (state)
        kmp_pkg::ST_IDLE: begin
          if (start_now) begin
            state <= kmp_pkg::ST_ACTIVE;
            edges <= 4'd1;
            tx_bit <= port_data_byte[0];
            shreg <= {1'b0, port_data_byte[7:1]};
          end
        end
        kmp_pkg::ST_ACTIVE: begin
          if (cur_fall) begin
            if (edges < `KMP_EDGE_STOP) begin
              edges <= edges + 4'd1;
            end
            if (!transmit_select) begin
              if (edges < `KMP_EDGE_PAR) begin
                shreg <= {cur_dat, shreg[7:1]};
              end else if (edges == `KMP_EDGE_PAR) begin
                par_bit <= cur_dat;
              end else begin
                state <= kmp_pkg::ST_DONE;
              end
            end else begin
              if (edges < 4'd8) begin
                tx_bit <= shreg[0];
                shreg <= {1'b0, shreg[7:1]};
              end else if (edges == 4'd8) begin
                // odd parity: high when data ones are even
                tx_bit <= ~^port_data_byte;
              end else if (edges == `KMP_EDGE_PAR) begin
                tx_bit <= 1'b1;
              end else if (!cur_dat) begin
                state <= kmp_pkg::ST_DONE;
              end
            end
          end
        end
        kmp_pkg::ST_DONE: begin
          state <= kmp_pkg::ST_DONE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------
  // status
  // -----------------------------------------------------------
  // cleared by reset or engine reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_flag <= 1'b0;
      end_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      active_channel_field <= 3'b000;
      frame_error_flag <= 1'b0;
    end else if (eng_rst) begin
      start_flag <= 1'b0;
      end_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      active_channel_field <= 3'b000;
      frame_error_flag <= 1'b0;
    end else begin
      if (start_now) begin
        start_flag <= 1'b1;
        active_channel_field <= chan;
      end
      if (state == kmp_pkg::ST_ACTIVE && cur_fall && edges == `KMP_EDGE_STOP) begin
        if (!transmit_select) begin
          end_flag <= 1'b1;
          frame_error_flag <= ~cur_dat;
          // even ones count is an error
          parity_error_flag <= ~^{shreg, par_bit};
        end else if (!cur_dat) begin
          end_flag <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------
  // ahb-lite slave
  // -----------------------------------------------------------
  // writes complete with no wait; reads take one wait state so that a
  // read right after a write sees the new value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_pend <= 1'b0;
      rd_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      if (rd_pend) begin
        hrdata <= {24'h00_0000, rd_val};
        hreadyout <= 1'b1;
      end else if (hsel && hready && htrans[1]) begin
        wr_pend <= hwrite;
        wr_addr <= haddr[7:0];
        rd_pend <= ~hwrite;
        rd_addr <= haddr[7:0];
        hreadyout <= hwrite;
      end
    end
  end

  always_comb begin
    case (rd_addr)
      `KMP_OFF_DATA: rd_val = port_data_byte;
      `KMP_OFF_STAT: rd_val = {1'b0, frame_error_flag, active_channel_field,
                               parity_error_flag, end_flag, start_flag};
      `KMP_OFF_CTL: rd_val = port_control;
      `KMP_OFF_OSIG: rd_val = {2'b00, line_output_control};
      `KMP_OFF_ISIG: rd_val = {2'b00, sync2};
      `KMP_OFF_IEN: rd_val = {5'b0_0000, interrupt_enables};
      default: rd_val = 8'h00;
    endcase
  end

  // -----------------------------------------------------------
  // software registers
  // -----------------------------------------------------------
  // reset selects receive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_control <= `KMP_CTL_RST;
      interrupt_enables <= 3'b000;
    end else if (sw_wr) begin
      if (wr_addr == `KMP_OFF_CTL) begin
        port_control <= wdat;
      end
      if (wr_addr == `KMP_OFF_IEN) begin
        interrupt_enables <= wdat[2:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_data_byte <= 8'h00;
    end else if (!eng_rst && !transmit_select && state == kmp_pkg::ST_ACTIVE && cur_fall && edges == `KMP_EDGE_STOP) begin
      port_data_byte <= shreg;
    end else if (sw_wr && wr_addr == `KMP_OFF_DATA) begin
      port_data_byte <= wdat;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_output_control <= `KMP_OSIG_RST;
    end else begin
      if (sw_wr && wr_addr == `KMP_OFF_OSIG) begin
        line_output_control <= wdat[5:0] | ((start_now && !eng_rst && transmit_select) ? 6'h07 : 6'h00);
      end else if (start_now && !eng_rst && transmit_select) begin
        line_output_control <= line_output_control | 6'h07;
      end
    end
  end

  // -----------------------------------------------------------
  // line drivers
  // -----------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      clk_low[i] = ~line_output_control[`KMP_OSIG_CLK + i]
                 | (eng_on & (state == kmp_pkg::ST_DONE))
                 | (eng_on & (state == kmp_pkg::ST_ACTIVE) & ~active_channel_field[i]);
      dat_low[i] = ~line_output_control[i]
                 | (eng_on & transmit_select & (state == kmp_pkg::ST_ACTIVE) & active_channel_field[i] & ~tx_bit);
    end
  end

  assign want_low = {clk_low, dat_low};

  always_comb begin
    for (int j = 0; j < 6; j++) begin
      if (want_low[j]) begin
        next_hcnt[j] = 2'd0;
      end else if (prev_low[j]) begin
        next_hcnt[j] = port_control[3:2];
      end else if (hcnt[j] != 2'd0) begin
        next_hcnt[j] = hcnt[j] - 2'd1;
      end else begin
        next_hcnt[j] = 2'd0;
      end
      next_oe[j] = want_low[j] | (next_hcnt[j] != 2'd0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_low <= 6'h00;
      line_out <= '1;
      line_oe <= '0;
      pullup_on <= '0;
      for (int j = 0; j < 6; j++) begin
        hcnt[j] <= 2'd0;
      end
    end else begin
      prev_low <= want_low;
      line_out <= ~want_low;
      line_oe <= next_oe;
      pullup_on <= {6{port_control[`KMP_CTL_WPU]}} & ~want_low;
      for (int j = 0; j < 6; j++) begin
        hcnt[j] <= next_hcnt[j];
      end
    end
  end

  // -----------------------------------------------------------
  // interrupt outputs
  // -----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_irq <= 3'b000;
    end else begin
      channel_irq <= {3{interrupt_enables[`KMP_IEN_DSM]}} & (eng_on ? deb : sync2.clk);
      if ((interrupt_enables[`KMP_IEN_SOT] && start_flag) || (interrupt_enables[`KMP_IEN_EOT] && end_flag)) begin
        channel_irq[0] <= 1'b1;
      end
    end
  end

endmodule

// ### kmp_port_regs.svh
// register map, field positions, reset values and timing counts for the port
`ifndef KMP_PORT_REGS_SVH
`define KMP_PORT_REGS_SVH

// -----------------------------------------------------------
// offsets
// -----------------------------------------------------------
`define KMP_OFF_DATA 8'h00
`define KMP_OFF_STAT 8'h04
`define KMP_OFF_CTL 8'h08
`define KMP_OFF_OSIG 8'h0C
`define KMP_OFF_ISIG 8'h10
`define KMP_OFF_IEN 8'h14

// -----------------------------------------------------------
// fields and resets
// -----------------------------------------------------------
`define KMP_CTL_EN 0
`define KMP_CTL_XMT 1
`define KMP_CTL_WPU 7
`define KMP_CTL_RST 8'h00
`define KMP_OSIG_RST 6'h07
`define KMP_OSIG_CLK 3
`define KMP_IEN_SOT 0
`define KMP_IEN_EOT 1
`define KMP_IEN_DSM 2

// -----------------------------------------------------------
// frame edge counts and debounce limit
// -----------------------------------------------------------
`define KMP_EDGE_PAR 4'd9
`define KMP_EDGE_STOP 4'd10
`define KMP_DBN_MAX 6'd32

`endif

// ### kmp_port_regs_props.sv
// checker for the port register block, bound to its top module
`timescale 1ns/1ps
`include "kmp_port_regs.svh"

module kmp_port_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // lines and interrupts
  input wire kmp_pkg::kmp_lines_t line_out,
  input wire kmp_pkg::kmp_lines_t line_oe,
  input wire kmp_pkg::kmp_lines_t pullup_on,
  input wire logic [2:0] channel_irq
);
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] ctl_sh;
  logic [7:0] osig_sh;
  logic [7:0] ien_sh;
  wire rd_take = hsel && hready && htrans[1] && !hwrite;

  // ----
  // shadows of software writes; hardware sets of data bits are not seen
  // ----
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_sh <= `KMP_CTL_RST;
      osig_sh <= 8'h07;
      ien_sh <= 8'h00;
    end else if (wr_pend) begin
      if (wr_addr == `KMP_OFF_CTL) ctl_sh <= hwdata[7:0];
      if (wr_addr == `KMP_OFF_OSIG) osig_sh <= hwdata[7:0];
      if (wr_addr == `KMP_OFF_IEN) ien_sh <= hwdata[7:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data changed outside a read");
  a_clk_forced: assert property (!osig_sh[3] [*3] |-> line_oe.clk[0] && !line_out.clk[0])
    else $error("clock line not forced low");
  a_dat_driven: assert property ((!ctl_sh[0] && !osig_sh[0]) [*3] |-> line_oe.dat[0] && !line_out.dat[0])
    else $error("data line not driven low");
  a_dat_released: assert property ((!ctl_sh[0] && osig_sh[0] && ctl_sh[3:2] == 2'b00) [*3] |-> !line_oe.dat[0])
    else $error("data line not released");
  a_irq_quiet: assert property ((ien_sh[2:0] == 3'b000) [*3] |-> channel_irq == 3'b000)
    else $error("interrupt raised while disabled");
  a_pull_off: assert property (!ctl_sh[7] [*3] |-> pullup_on == 6'h00)
    else $error("pull-up on while disabled");
  a_pull_on: assert property (ctl_sh[7] [*3] |-> pullup_on == ~(line_oe & ~line_out))
    else $error("pull-up not on while line released");
  a_high_drive: assert property ($rose(line_out.dat[0]) && ctl_sh[3:2] == 2'b01 |-> line_oe.dat[0] ##1 !line_oe.dat[0])
    else $error("high drive not one cycle");

  cover property (rd_take);
  cover property ($rose(channel_irq[0]));
  cover property (line_oe.dat[0] && line_out.dat[0]);
endmodule

bind kmp_port_regs kmp_port_regs_props i_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .line_out(line_out), .line_oe(line_oe), .pullup_on(pullup_on),
  .channel_irq(channel_irq));

// ### test_kmp_port_regs.sv
// self-checking bench for the port register block
`timescale 1ns/1ps
`include "kmp_port_regs.svh"

module test_kmp_port_regs;
  logic clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  kmp_pkg::kmp_lines_t line_in;
  kmp_pkg::kmp_lines_t line_out;
  kmp_pkg::kmp_lines_t line_oe;
  kmp_pkg::kmp_lines_t pullup_on;
  logic [2:0] channel_irq;
  logic dev_clk_low;
  logic dev_dat_low;
  int num_errors = 0;
  int compares = 0;
  int exp_q[$];
  logic [7:0] b;
  logic [7:0] v;
  logic p;
  logic ok;

  // open-drain wires with pull-ups; only channel one has a device
  assign line_in = kmp_pkg::kmp_lines_t'(~(line_oe & ~line_out) & ~{2'b00, dev_clk_low, 2'b00, dev_dat_low});

  kmp_port_regs i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .pullup_on(pullup_on), .channel_irq(channel_irq));
  kmp_dev_model i_dev (.clk_line(line_in.clk[0]), .dat_line(line_in.dat[0]), .clk_low(dev_clk_low),
    .dat_low(dev_dat_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // entered just after a rising edge; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  initial begin
    #200_000;
    num_errors++;
    test_done();
  end

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    rst = 1'b1;
    void'($urandom(32'h1b56));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`KMP_OFF_CTL, 32'h0000_0000);
    rd(`KMP_OFF_OSIG, 32'h0000_0007);
    rd(`KMP_OFF_IEN, 32'h0000_0000);
    rd(`KMP_OFF_STAT, 32'h0000_0000);
    rd(`KMP_OFF_ISIG, 32'h0000_0007);
    wr(8'h18, 32'h0000_00ff);
    rd(8'h18, 32'h0000_0000);
    // manual line control with the engine off and the weak pull-up on
    wr(`KMP_OFF_CTL, 32'h0000_0080);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom) & 8'h3f;
      wr(`KMP_OFF_OSIG, {24'h00_0000, v});
      repeat (4) @(posedge clk);
      chk({26'h0, pullup_on}, {24'h00_0000, v});
      rd(`KMP_OFF_ISIG, {24'h00_0000, v});
    end
    wr(`KMP_OFF_OSIG, 32'h0000_003f);
    wr(`KMP_OFF_IEN, 32'h0000_0004);
    for (int k = 0; k < 2; k++) begin
      i_dev.hold_clk(k == 0);
      repeat (6) @(posedge clk);
      chk({29'h0, channel_irq}, (k == 0) ? 32'h0000_0006 : 32'h0000_0007);
    end
    // receive, the second frame with parity and stop faults
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      wr(`KMP_OFF_OSIG, 32'h0000_0007);
      wr(`KMP_OFF_IEN, 32'h0000_0003);
      wr(`KMP_OFF_CTL, {25'h0, 3'(k), 4'h1});
      wr(`KMP_OFF_OSIG, 32'h0000_000f);
      // let the released clock settle through debounce first
      repeat (8) @(posedge clk);
      i_dev.send(b, k[0], k[0]);
      repeat (20) @(posedge clk);
      rd(`KMP_OFF_STAT, (k == 0) ? 32'h0000_000b : 32'h0000_004f);
      rd(`KMP_OFF_DATA, exp_q.pop_front());
      chk({29'h0, channel_irq}, 32'h0000_0001);
      // start enable dropped after its interrupt
      wr(`KMP_OFF_IEN, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk({29'h0, channel_irq}, 32'h0000_0001);
      wr(`KMP_OFF_IEN, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk({29'h0, channel_irq}, 32'h0000_0000);
      wr(`KMP_OFF_OSIG, 32'h0000_0007);
      rd(`KMP_OFF_STAT, 32'h0000_0000);
    end
    // transmit with one cycle of high drive
    b = 8'($urandom);
    wr(`KMP_OFF_CTL, 32'h0000_0007);
    // data written in transmit with every channel off
    wr(`KMP_OFF_DATA, {24'h00_0000, b});
    // clearing the data bit is the transmit request
    wr(`KMP_OFF_OSIG, 32'h0000_0006);
    wr(`KMP_OFF_OSIG, 32'h0000_000e);
    i_dev.recv(v, p, ok);
    repeat (20) @(posedge clk);
    chk({24'h00_0000, v}, {24'h00_0000, b});
    chk({31'h0, p}, {31'h0, ~^b});
    chk({31'h0, ok}, 32'h0000_0001);
    rd(`KMP_OFF_STAT, 32'h0000_000b);
    rd(`KMP_OFF_OSIG, 32'h0000_000f);
    // rewrite the data bits so the checker's shadow matches the hardware set
    wr(`KMP_OFF_OSIG, 32'h0000_000f);
    wr(`KMP_OFF_CTL, 32'h0000_0000);
    rd(`KMP_OFF_STAT, 32'h0000_0000);
    test_done();
  end
endmodule
